// ===== rtl/fifo_wr_pkg.sv
// shared constants and types for the fifo write port
package fifo_wr_pkg;
   localparam int DATA_W = 36;
   localparam int CFG_W = 8;
   localparam int ADDR_W = 6;
   localparam int DEPTH = 64;
   localparam int CFG_N = 4;
   localparam int CFG_AW = 2;
   localparam logic [ADDR_W:0] HALF_LEVEL = 7'h20;
   // configuration register indices
   localparam logic [CFG_AW-1:0] CFG_PAF_IDX = 2'h0;
   localparam logic [CFG_AW-1:0] CFG_PAE_IDX = 2'h1;
   // config values after master clear; port width value after reset
   localparam logic [CFG_W-1:0] CFG_PAF_RST = 8'h08;
   localparam logic [CFG_W-1:0] CFG_PAE_RST = 8'h08;
   localparam logic [CFG_W-1:0] CFG_OTHER_RST = 8'h00;
   localparam logic [2:0] PORT_WIDTH_RST = 3'h7;

   typedef struct packed {
      logic load_select;
      logic gate_n;
      logic [DATA_W-1:0] data;
   } wr_word_t;

   typedef enum logic [1:0] {
      CLR_RUN = 2'b00,
      CLR_MASTER = 2'b01,
      CLR_PARTIAL = 2'b11
   } clr_state_t;
endpackage

// ===== rtl/wr_skid_buf.sv
// two-entry valid/ready buffer in the write data path
`timescale 1ns/1ps
module wr_skid_buf
   import fifo_wr_pkg::*;
(
   input wire logic i_sys_clk, // system clock
   input wire logic i_rstn, // sync reset, active low
   input wire logic i_flush, // drop contents
   input wire fifo_wr_pkg::wr_word_t i_data, // incoming word
   input wire logic i_valid, // incoming valid
   output logic o_ready, // room available
   output fifo_wr_pkg::wr_word_t o_data, // head word
   output logic o_valid, // head valid
   input wire logic i_ready // consumer takes head
);
   wr_word_t slot [2];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_ready = (count != 2'h2);
   assign o_valid = (count != 2'h0);
   assign o_data = slot[rd_ptr];

   // storage
   always_ff @(posedge i_sys_clk)
   begin
      if (push)
         slot[wr_ptr] <= i_data;
   end

   // pointers and occupancy
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || i_flush)
      begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // wr_skid_buf

// ===== rtl/wr_flag_gen.sv
// status flags from fill level, registered on the write clock
`timescale 1ns/1ps
module wr_flag_gen
   import fifo_wr_pkg::*;
(
   input wire logic i_sys_clk, // write clock
   input wire logic i_clear, // clear flags
   input wire logic [ADDR_W:0] i_level, // words held
   input wire logic [CFG_W-1:0] i_paf_offset, // near full offset
   output logic o_full_n, // full, low active
   output logic o_half_n, // half level, low active
   output logic o_near_full_n // near full, low active
);
   logic [ADDR_W+1:0] room;

   assign room = {1'b0, 7'(DEPTH)} - {1'b0, i_level};

   // flags are deasserted (high) after any clear
   always_ff @(posedge i_sys_clk)
   begin
      if (i_clear)
      begin
         o_full_n <= 1'b1;
         o_half_n <= 1'b1;
         o_near_full_n <= 1'b1;
      end
      else
      begin
         o_full_n <= !(i_level == 7'(DEPTH)); // see RULE_13
         o_half_n <= !(i_level >= HALF_LEVEL); // see RULE_14
         o_near_full_n <= !(room <= {1'b0, i_paf_offset}); // see RULE_14
      end
   end
endmodule // wr_flag_gen

// ===== rtl/fifo_write_port.sv
// write port front end and clear logic of a synchronous fifo
// What this block does
// RULE_01: master clear zeroes pointers, flags and output register.
// RULE_02: master clear reloads every configuration register with its default.
// RULE_03: partial clear zeroes pointers, flags and output register.
// RULE_04: partial clear keeps configuration registers unchanged.
// RULE_05: one three-bit width select serves both ports.
// RULE_06: data captured only on clock edges with write enable low.
// RULE_07: load select high writes memory, low writes configuration.
// RULE_08: configuration uses low eight bits; memory keeps the bits of the selected width, all 36 only at select 7.
// RULE_09: write enable is active low; one write per enabled edge.
// RULE_10: word stored only when input gate is low.
// RULE_11: pointer advances on every enabled write, gate or not.
// RULE_12: write data bus is 36 bits wide.
// RULE_13: full flag low when no free location, on write clock.
// RULE_14: half and near-full flags on write clock, offset programmed.
// RULE_15: writes while full wait in the two-entry buffer, memory and pointer unchanged; once it holds two, further writes are refused.
`timescale 1ns/1ps
module fifo_write_port
   import fifo_wr_pkg::*;
(
   input wire logic i_sys_clk, // write clock, 200 MHz
   input wire logic i_rstn, // sync reset, active low
   input wire logic i_master_clear_n, // master clear pin
   input wire logic i_partial_clear_n, // partial clear pin
   input wire logic [2:0] i_port_width_select, // shared word width pins
   input wire logic i_cfg_load_select, // high memory, low config
   input wire logic i_wr_en_n, // write enable, low active
   input wire logic i_input_gate_n, // input enable, low active
   input wire logic [fifo_wr_pkg::DATA_W-1:0] i_data, // write data
   output logic o_wr_ready, // buffer can accept, high
   input wire logic i_rd_en, // consumer read strobe
   input wire logic i_cfg_rd, // read config register
   input wire logic [fifo_wr_pkg::CFG_AW-1:0] i_cfg_addr, // config index to read
   output logic [fifo_wr_pkg::DATA_W-1:0] o_q, // output register
   output logic o_q_valid, // output register loaded
   output logic [2:0] o_port_width, // width in force for both ports
   output logic [fifo_wr_pkg::CFG_W-1:0] o_paf_offset, // near full offset
   output logic [fifo_wr_pkg::CFG_W-1:0] o_pae_offset, // near empty offset
   output logic o_full_flag_n, // full, low active
   output logic o_half_level_flag_n, // half full, low active
   output logic o_near_full_flag_n, // near full, low active
   output logic [fifo_wr_pkg::ADDR_W:0] o_level, // words held
   output logic o_overflow // pulse: write refused while full
);
   import fifo_wr_pkg::*;

   // pin synchronisers, stage one read only by stage two
   logic [DATA_W+5:0] pin_s1;
   logic [DATA_W+5:0] pin_s2;
   logic [2:0] width_s1;
   logic [2:0] width_s2;
   logic mclr_n;
   logic pclr_n;
   logic wen_n;
   wr_word_t in_word;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         pin_s1 <= '1;
         pin_s2 <= '1;
         width_s1 <= PORT_WIDTH_RST;
         width_s2 <= PORT_WIDTH_RST;
      end
      else
      begin
         pin_s1 <= {i_master_clear_n, i_partial_clear_n, i_wr_en_n,
                    i_cfg_load_select, i_input_gate_n, i_data, 1'b1};
         pin_s2 <= pin_s1;
         width_s1 <= i_port_width_select;
         width_s2 <= width_s1;
      end
   end

   assign mclr_n = pin_s2[DATA_W+5];
   assign pclr_n = pin_s2[DATA_W+4];
   assign wen_n = pin_s2[DATA_W+3];
   assign in_word.load_select = pin_s2[DATA_W+2];
   assign in_word.gate_n = pin_s2[DATA_W+1];
   assign in_word.data = pin_s2[DATA_W:1]; // see RULE_12

   // clear sequencer
   clr_state_t clr_state;
   logic clr_any;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         clr_state <= CLR_MASTER;
      else if (!mclr_n)
         clr_state <= CLR_MASTER;
      else if (!pclr_n)
         clr_state <= CLR_PARTIAL;
      else
         clr_state <= CLR_RUN;
   end

   assign clr_any = (clr_state != CLR_RUN) || !mclr_n || !pclr_n;

   // mask data to the selected width
   function automatic logic [DATA_W-1:0] width_mask(input logic [2:0] sel);
      unique case (sel)
         3'h0: width_mask = 36'h0_0000_01ff;
         3'h1: width_mask = 36'h0_0000_0fff;
         3'h2: width_mask = 36'h0_0000_ffff;
         3'h3: width_mask = 36'h0_0003_ffff;
         3'h4: width_mask = 36'h0_000f_ffff;
         3'h5: width_mask = 36'h0_00ff_ffff;
         3'h6: width_mask = 36'h0_ffff_ffff;
         3'h7: width_mask = 36'hf_ffff_ffff;
      endcase
   endfunction

   // the width select is latched while any clear runs
   logic [2:0] port_width;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         port_width <= PORT_WIDTH_RST;
      else if (clr_any)
         port_width <= width_s2; // see RULE_05
   end

   // two-entry buffer between pins and memory
   wr_word_t buf_word;
   logic buf_valid;
   logic buf_ready;
   logic in_ready;

   wr_skid_buf u_skid (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_flush(clr_any),
      .i_data(in_word),
      .i_valid(!wen_n && !clr_any), // see RULE_06, RULE_09
      .o_ready(in_ready),
      .o_data(buf_word),
      .o_valid(buf_valid),
      .i_ready(buf_ready)
   );

   // memory, pointers and level
   logic [DATA_W-1:0] mem [DEPTH];
   logic [ADDR_W-1:0] wr_ptr;
   logic [ADDR_W-1:0] rd_ptr;
   logic [ADDR_W:0] level;
   logic full;
   logic mem_wr;
   logic cfg_wr;
   logic do_rd;
   logic q_valid;

   assign full = (level == 7'(DEPTH));
   assign do_rd = i_rd_en && (level != 7'h0) && !clr_any;
   // config writes always drain; memory writes wait while full
   assign buf_ready = !buf_word.load_select || !full || do_rd;
   assign mem_wr = buf_valid && buf_word.load_select && buf_ready; // see RULE_07, RULE_15
   // no config write lands while a clear runs
   assign cfg_wr = buf_valid && !buf_word.load_select && !clr_any; // see RULE_07, RULE_04

   // storage only when the input gate is open
   always_ff @(posedge i_sys_clk)
   begin
      if (mem_wr && !buf_word.gate_n) // see RULE_10
         mem[wr_ptr] <= buf_word.data & width_mask(port_width); // see RULE_08
   end

   // write pointer moves on every accepted write, gate open or not; read pointer on each read
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || clr_any)
      begin
         wr_ptr <= '0; // see RULE_01, RULE_03
         rd_ptr <= '0;
         level <= '0;
      end
      else
      begin
         if (mem_wr)
            wr_ptr <= wr_ptr + 6'h1; // see RULE_11
         if (do_rd)
            rd_ptr <= rd_ptr + 6'h1;
         level <= level + {6'h0, mem_wr} - {6'h0, do_rd};
      end
   end

   // configuration registers
   logic [CFG_W-1:0] cfg [CFG_N];

   function automatic logic [CFG_W-1:0] cfg_default(input int idx);
      if (idx == int'(CFG_PAF_IDX))
         cfg_default = CFG_PAF_RST;
      else if (idx == int'(CFG_PAE_IDX))
         cfg_default = CFG_PAE_RST;
      else
         cfg_default = CFG_OTHER_RST;
   endfunction

   // config index advances after each config write
   logic [CFG_AW-1:0] cfg_wr_idx;

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || clr_state == CLR_MASTER || !mclr_n)
         cfg_wr_idx <= '0;
      else if (cfg_wr)
         cfg_wr_idx <= cfg_wr_idx + 2'h1;
   end

   genvar g;
   generate
      for (g = 0; g < CFG_N; g++)
      begin : g_cfg
         always_ff @(posedge i_sys_clk)
         begin
            if (!i_rstn || clr_state == CLR_MASTER || !mclr_n)
               cfg[g] <= cfg_default(g); // see RULE_02
            else if (cfg_wr && cfg_wr_idx == CFG_AW'(g))
               cfg[g] <= buf_word.data[CFG_W-1:0]; // see RULE_04, RULE_08
         end
      end
   endgenerate

   // output register: memory word or config byte
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || clr_any)
      begin
         o_q <= '0; // see RULE_01, RULE_03
         q_valid <= 1'b0;
      end
      else if (i_cfg_rd)
      begin
         o_q <= {{(DATA_W-CFG_W){1'b0}}, cfg[i_cfg_addr]}; // see RULE_08
         q_valid <= 1'b1;
      end
      else if (do_rd)
      begin
         o_q <= mem[rd_ptr];
         q_valid <= 1'b1;
      end
   end

   // status flags
   logic full_n;
   logic half_n;
   logic near_n;

   wr_flag_gen u_flags (
      .i_sys_clk(i_sys_clk),
      .i_clear(!i_rstn || clr_any), // see RULE_01, RULE_03
      .i_level(level),
      .i_paf_offset(cfg[CFG_PAF_IDX]),
      .o_full_n(full_n),
      .o_half_n(half_n),
      .o_near_full_n(near_n)
   );

   // registered outputs
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_full_flag_n <= 1'b1;
         o_half_level_flag_n <= 1'b1;
         o_near_full_flag_n <= 1'b1;
         o_level <= '0;
         o_port_width <= PORT_WIDTH_RST;
         o_paf_offset <= CFG_PAF_RST;
         o_pae_offset <= CFG_PAE_RST;
         o_q_valid <= 1'b0;
         o_wr_ready <= 1'b0;
         o_overflow <= 1'b0;
      end
      else
      begin
         o_full_flag_n <= full_n; // see RULE_13
         o_half_level_flag_n <= half_n; // see RULE_14
         o_near_full_flag_n <= near_n; // see RULE_14
         o_level <= level;
         o_port_width <= port_width; // see RULE_05
         o_paf_offset <= cfg[CFG_PAF_IDX];
         o_pae_offset <= cfg[CFG_PAE_IDX];
         o_q_valid <= q_valid;
         o_wr_ready <= in_ready && !clr_any;
         o_overflow <= !wen_n && !in_ready && !clr_any; // see RULE_15
      end
   end
endmodule // fifo_write_port

// ===== verification/fifo_write_port_sva.sv
// assertion checker for the fifo write port
`timescale 1ns/1ps
module fifo_write_port_sva
   import fifo_wr_pkg::*;
(
   input wire logic i_sys_clk, // clock
   input wire logic i_rstn, // sync reset
   input wire logic i_master_clear_n, // master clear
   input wire logic i_partial_clear_n, // partial clear
   input wire logic [fifo_wr_pkg::ADDR_W:0] o_level, // fill count
   input wire logic [fifo_wr_pkg::DATA_W-1:0] o_q, // output register
   input wire logic [2:0] o_port_width, // width in force
   input wire logic [fifo_wr_pkg::CFG_W-1:0] o_paf_offset, // config 0
   input wire logic [fifo_wr_pkg::CFG_W-1:0] o_pae_offset, // config 1
   input wire logic o_full_flag_n, // full
   input wire logic o_half_level_flag_n, // half
   input wire logic o_near_full_flag_n // near full
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // clear pins held long enough to pass the synchroniser
   sequence s_mclr;
      !i_master_clear_n [*6];
   endsequence
   sequence s_pclr;
      (!i_partial_clear_n && i_master_clear_n) [*6];
   endsequence
   sequence s_run;
      (i_master_clear_n && i_partial_clear_n) [*4];
   endsequence
   // flags trail the fill count by one edge
   chk_full_set: assert property ((o_level == DEPTH) [*2] |-> !o_full_flag_n)
      else $error("full flag high at full level");
   chk_full_clr: assert property ((o_level < DEPTH) [*2] |-> o_full_flag_n)
      else $error("full flag low below full");
   chk_half_set: assert property ((o_level >= 32) [*2] |-> !o_half_level_flag_n)
      else $error("half flag high at half level");
   chk_near_set: assert property ((DEPTH - o_level <= o_paf_offset) [*2]
      |-> !o_near_full_flag_n)
      else $error("near full flag high within offset");
   chk_level_step: assert property (o_level != $past(o_level) |-> o_level == 0
      || o_level - $past(o_level) == 1 || $past(o_level) - o_level == 1)
      else $error("fill count jumped by more than one");
   // clears
   chk_mclr_zero: assert property (s_mclr |-> o_level == 0 && o_q == '0 && o_full_flag_n
      && o_half_level_flag_n && o_near_full_flag_n)
      else $error("master clear left state");
   chk_mclr_cfg: assert property (s_mclr |-> o_paf_offset == CFG_PAF_RST
      && o_pae_offset == CFG_PAE_RST)
      else $error("master clear left config");
   chk_pclr_zero: assert property (s_pclr |-> o_level == 0 && o_q == '0 && o_full_flag_n
      && o_half_level_flag_n && o_near_full_flag_n)
      else $error("partial clear left state");
   chk_pclr_keep: assert property (s_pclr |-> $stable(o_paf_offset)
      && $stable(o_pae_offset))
      else $error("partial clear changed config");
   chk_width_hold: assert property (s_run |-> $stable(o_port_width))
      else $error("width changed outside clear");
endmodule // fifo_write_port_sva

// ===== verification/wr_producer.sv
// producer model driving the write pins
`timescale 1ns/1ps
module wr_producer
   import fifo_wr_pkg::*;
(
   input wire logic i_sys_clk, // clock
   input wire logic i_ready, // port has room
   output logic o_wr_en_n = 1'b1, // write enable, low active
   output logic o_load = 1'b1, // load select
   output logic o_gate_n = 1'b0, // input gate, low active
   output logic [fifo_wr_pkg::DATA_W-1:0] o_data = '0 // write data
);
   int n_timeouts = 0;
   // one word per edge; enable held high while no room
   task automatic put(input logic ld, input logic g, input logic [DATA_W-1:0] d);
      #1;
      for (int k = 0; k < 64 && !i_ready; k++)
      begin
         @(posedge i_sys_clk);
         o_wr_en_n <= 1'b1;
         #1;
      end
      if (!i_ready)
         n_timeouts++;
      @(posedge i_sys_clk);
      o_wr_en_n <= 1'b0;
      o_load <= ld;
      o_gate_n <= g;
      o_data <= d;
   endtask
   // release: enable high, data lines toggled
   task automatic stop();
      @(posedge i_sys_clk);
      o_wr_en_n <= 1'b1;
      o_data <= ~o_data;
   endtask
endmodule // wr_producer

// ===== verification/fifo_write_port_tb.sv
// self-checking testbench for the fifo write port
`timescale 1ns/1ps
module fifo_write_port_tb;
   import fifo_wr_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_master_clear_n = 1'b1;
   logic i_partial_clear_n = 1'b1;
   logic [2:0] i_port_width_select = 3'h7;
   logic i_cfg_load_select, i_wr_en_n, i_input_gate_n, o_wr_ready;
   logic [DATA_W-1:0] i_data, o_q;
   logic i_rd_en = 1'b0;
   logic i_cfg_rd = 1'b0;
   logic [CFG_AW-1:0] i_cfg_addr = 2'h0;
   logic o_q_valid, o_full_flag_n, o_half_level_flag_n, o_near_full_flag_n, o_overflow;
   logic [2:0] o_port_width;
   logic [CFG_W-1:0] o_paf_offset, o_pae_offset;
   logic [ADDR_W:0] o_level;
   int err_count = 0;
   int n_checks = 0;
   int exp_lvl = 0;
   int n_ovf = 0;
   // count refused-write pulses away from the launching edge
   always @(negedge i_sys_clk)
      if (o_overflow === 1'b1)
         n_ovf++;
   always #2.5 i_sys_clk = ~i_sys_clk;
   fifo_write_port i_dut (.i_sys_clk, .i_rstn, .i_master_clear_n, .i_partial_clear_n,
      .i_port_width_select, .i_cfg_load_select, .i_wr_en_n, .i_input_gate_n, .i_data,
      .o_wr_ready, .i_rd_en, .i_cfg_rd, .i_cfg_addr, .o_q, .o_q_valid, .o_port_width,
      .o_paf_offset, .o_pae_offset, .o_full_flag_n, .o_half_level_flag_n,
      .o_near_full_flag_n, .o_level, .o_overflow);
   wr_producer i_prod (.i_sys_clk(i_sys_clk), .i_ready(o_wr_ready), .o_wr_en_n(i_wr_en_n),
      .o_load(i_cfg_load_select), .o_gate_n(i_input_gate_n), .o_data(i_data));
   // compare and count
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // wait n edges, then sample away from the edge
   task automatic settle(input int n);
      repeat (n) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
   endtask
   task automatic pop(input logic c, input logic [CFG_AW-1:0] a);
      @(posedge i_sys_clk);
      i_rd_en <= !c;
      i_cfg_rd <= c;
      i_cfg_addr <= a;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      i_cfg_rd <= 1'b0;
      settle(1);
   endtask
   task automatic clr(input logic m);
      @(posedge i_sys_clk);
      i_master_clear_n <= !m;
      i_partial_clear_n <= m;
      settle(8);
      @(posedge i_sys_clk);
      i_master_clear_n <= 1'b1;
      i_partial_clear_n <= 1'b1;
      settle(6);
      exp_lvl = 0;
   endtask
   task automatic state(input logic [ADDR_W:0] l, input logic [2:0] f);
      check(36'(o_level), 36'(l));
      check(36'({o_half_level_flag_n, o_near_full_flag_n, o_full_flag_n}), 36'(f));
   endtask
   task automatic fill(input int n, input logic [2:0] f);
      for (int i = 0; i < n; i++)
         i_prod.put(1'b1, 1'b0, 36'(i));
      i_prod.stop();
      settle(8);
      exp_lvl = (exp_lvl + n > DEPTH) ? DEPTH : exp_lvl + n;
      state(7'(exp_lvl), f);
   endtask
   task automatic t_cfg();
      i_prod.put(1'b0, 1'b0, 36'hfffffff05);
      i_prod.put(1'b0, 1'b0, 36'h800000011);
      i_prod.stop();
      settle(8);
      check(36'({o_paf_offset, o_pae_offset}), 36'h0511);
      check(36'(o_level), 36'h0);
      pop(1'b1, 2'h1);
      check(o_q, 36'h11);
      check(36'(o_q_valid), 36'h1);
   endtask
   task automatic t_mem();
      i_prod.put(1'b1, 1'b0, 36'h912345678);
      i_prod.put(1'b1, 1'b1, 36'h0aaaa5555);
      i_prod.put(1'b1, 1'b0, 36'hf0f0f0f0f);
      i_prod.stop();
      settle(8);
      check(36'(o_level), 36'h3);
      pop(1'b0, 2'h0);
      check(o_q, 36'h912345678);
      pop(1'b0, 2'h0);
      pop(1'b0, 2'h0);
      check(o_q, 36'hf0f0f0f0f);
   endtask
   initial
   begin
      repeat (12) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      settle(8);
      check(36'({o_port_width, o_paf_offset, o_pae_offset}), 36'h70808);
      state(7'h0, 3'h7);
      t_cfg();
      t_mem();
      fill(1, 3'h7);
      clr(1'b0);
      state(7'h0, 3'h7);
      check(o_q, 36'h0);
      check(36'(o_q_valid), 36'h0);
      check(36'({o_paf_offset, o_pae_offset}), 36'h0511);
      fill(31, 3'h7);
      fill(1, 3'h3);
      fill(26, 3'h3);
      fill(1, 3'h1);
      fill(4, 3'h1);
      fill(1, 3'h0);
      fill(1, 3'h0);
      fill(3, 3'h0);
      check(36'(n_ovf), 36'h2);
      check(36'(i_prod.n_timeouts), 36'h0);
      @(posedge i_sys_clk);
      i_port_width_select <= 3'h2;
      clr(1'b1);
      check(36'({o_port_width, o_paf_offset, o_pae_offset}), 36'h20808);
      state(7'h0, 3'h7);
      check(o_q, 36'h0);
      final_report();
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      err_count++;
      final_report();
   end
endmodule // fifo_write_port_tb
bind fifo_write_port fifo_write_port_sva i_sva (.i_sys_clk, .i_rstn, .i_master_clear_n,
   .i_partial_clear_n, .o_level, .o_q, .o_port_width, .o_paf_offset, .o_pae_offset,
   .o_full_flag_n, .o_half_level_flag_n, .o_near_full_flag_n);
